// File: hw/socket_seq_pkg.sv
// Purpose: constants and types shared by the socket module sequencer
// Assumes: one core clock, register port with one-cycle read latency
// Notes: the option values below are the build-time socket options
package socket_seq_pkg;
  localparam int MOD_REQ = 3;
  localparam int NUM_MOD = 1 << $clog2(MOD_REQ);
  localparam int MW = $clog2(NUM_MOD);
  localparam int NUM_TRIG = 8;
  localparam int TW = $clog2(NUM_TRIG);
  localparam int NUM_HW = 2;
  localparam int RST_MAX = 256;
  localparam int CFG_W = 15;
  localparam logic START_IN_SHUTDOWN = 1'b0;
  localparam logic SOE_RESET = 1'b1;
  localparam logic SKIP_STARTUP = 1'b0;
  localparam logic HAS_POR = 1'b1;
  localparam logic [1:0] POR_MOD = 2'h0;
  localparam logic HAS_STATUS_CH = 1'b1;
  localparam logic HAS_CONTROL_CH = 1'b1;
  localparam logic NEEDS_CLEARING = 1'b1;
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_SW_TRIG = 8'h08;
  localparam logic [7:0] ADDR_MOD_SEL = 8'h0c;
  localparam logic [7:0] ADDR_MOD_CFG = 8'h10;
  localparam logic [7:0] ADDR_BS0_ADDR = 8'h14;
  localparam logic [7:0] ADDR_BS0_SIZE = 8'h18;
  localparam logic [7:0] ADDR_BS1_ADDR = 8'h1c;
  localparam logic [7:0] ADDR_BS1_SIZE = 8'h20;
  localparam logic [7:0] ADDR_TRIG_SEL = 8'h24;
  localparam logic [7:0] ADDR_TRIG_MAP = 8'h28;
  localparam logic [7:0] ADDR_SW_ACK = 8'h2c;
  localparam int CTRL_SOE = 0;
  localparam int CTRL_SD = 1;
  localparam int CTRL_GO = 2;
  localparam int ACK_SD = 0;
  localparam int ACK_SU = 1;
  localparam int ST_LOADED = 9;
  localparam int ST_ERR_F = 12;
  localparam int ST_ERR_A = 13;
  localparam int TRIG_LOCK = 8;
  localparam int CFG_VALID = 14;
  localparam logic [CFG_W-1:0] CFG_RST_USED = 15'h4000;
  localparam logic [CFG_W-1:0] CFG_RST_FREE = 15'h0000;
  typedef enum logic [1:0] {SD_NONE = 2'h0, SD_HW = 2'h1, SD_HW_SW = 2'h2,
    SD_SW_HW = 2'h3} shut_t;
  typedef enum logic [1:0] {RS_NONE = 2'h0, RS_HIGH = 2'h1, RS_LOW = 2'h2,
    RS_BAD = 2'h3} rst_t;
  typedef struct packed {
    logic valid;
    shut_t shut;
    logic sw_start;
    rst_t rst;
    logic [7:0] rst_len;
    logic has_clear;
  } mod_cfg_t;
  typedef struct packed {
    logic [31:0] addr;
    logic [31:0] size;
  } fetch_t;
  typedef enum logic [8:0] {
    ST_ACTIVE = 9'h001, ST_SD_HW = 9'h002, ST_SD_SW = 9'h004,
    ST_CLEAR = 9'h008, ST_FETCH = 9'h010, ST_BOOT = 9'h020,
    ST_RESET = 9'h040, ST_SU_SW = 9'h080, ST_SHUTDOWN = 9'h100
  } state_t;
endpackage

// File: hw/socket_module_sequencer.sv
// Purpose: per-socket sequencer that swaps reconfigurable modules on triggers
// Assumes: fetch path and modules run on clk_sys; hw_trigger pins are async
// Notes: register port answers every access; unmapped reads return zero
//
// Overview of operation
// - with start-in-shutdown set, leave reset into the shutdown state
// - with shutdown-on-error set, any detected error enters shutdown
// - leaving reset with a module loaded runs its start-up steps
// - skip-startup option omits start-up steps after own reset
// - power-on module option marks that module loaded at reset
// - module storage is requested count rounded up to a power of two
// - not-required gets no notice; hardware-only notifies module, not software
// - hardware-then-software: module notice completes before software notice
// - software-then-hardware: software notice first, then module notice
// - software start-up type notifies software after load; not-required does not
// - after load reset module active high, active low, or not at all
// - module reset lasts the configured cycles plus one, at most 256
// - a loaded module's clearing bitstream is loaded before the next module
// - a set number of triggers come from hardware pins, rest from software
// - by default trigger T selects module T modulo module count
// - adding a module remaps all unlocked triggers with the new count
// - a locked trigger keeps its module when modules are added
// - deleting a trigger's locked module unlocks it back to default
// - status and control stream channels can each be included or omitted
`timescale 1ns/1ps
module socket_module_sequencer
  import socket_seq_pkg::*;
(
  input wire logic clk_sys, // core clock
  input wire logic rst, // synchronous reset, high
  input wire logic [7:0] addr, // register byte address
  input wire logic [31:0] wdata, // register write data
  input wire logic wr, // write strobe
  input wire logic rd, // read strobe
  output logic [31:0] rdata, // read data, cycle after rd
  input wire logic [NUM_HW-1:0] hw_trigger, // async trigger pins
  output logic rm_shutdown_req, // removal notice to module
  input wire logic rm_shutdown_ack, // module ready for removal
  output logic rm_reset, // module reset, polarity per module
  output logic fetch_req, // bitstream fetch request
  output fetch_t fetch, // bitstream address and size
  input wire logic fetch_done, // fetch finished
  input wire logic fetch_err, // fetch failed
  output logic status_valid, // status stream valid
  input wire logic status_ready, // status stream ready
  output logic [15:0] status_data, // status stream word
  input wire logic ctrl_valid, // control stream valid
  output logic ctrl_ready, // control stream ready
  input wire logic [7:0] ctrl_data // control stream trigger id
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  state_t state_reg, state_next;
  mod_cfg_t cfg_reg [NUM_MOD];
  fetch_t bs0_reg [NUM_MOD];
  fetch_t bs1_reg [NUM_MOD];
  logic [NUM_MOD-1:0] vld;
  logic [MW:0] cnt;
  logic [MW-1:0] sel_reg, loaded_reg, tgt_reg, tgt;
  logic loaded_valid_reg, soe_reg, err_f_reg, err_a_reg, sw_sd_reg, sw_su_reg;
  logic [TW-1:0] tsel_reg, sw_id_reg, trig_id;
  logic sw_pend_reg, trig_go, ctrl_take, sw_take, sd_cmd, go_cmd;
  logic [NUM_HW-1:0] hw_pend_reg, hw_rise, hw_take;
  logic [NUM_TRIG-1:0] lock_reg;
  logic [MW-1:0] lmod_reg [NUM_TRIG];
  logic [MW-1:0] eff [NUM_TRIG];
  logic [7:0] rst_cnt_reg;
  logic aligned, load_ok, del_now, map_wr, sd_ack, su_ack, fetching;
  mod_cfg_t cur, tcfg;
  state_t after_sd, err_st;

  assign cur = cfg_reg[loaded_reg];
  assign tcfg = cfg_reg[tgt_reg];
  assign sd_cmd = wr && addr == ADDR_CTRL && wdata[CTRL_SD];
  assign go_cmd = wr && addr == ADDR_CTRL && wdata[CTRL_GO];
  assign sd_ack = wr && addr == ADDR_SW_ACK && wdata[ACK_SD];
  assign su_ack = wr && addr == ADDR_SW_ACK && wdata[ACK_SU];
  assign map_wr = wr && addr == ADDR_TRIG_MAP;
  assign del_now = wr && addr == ADDR_MOD_CFG && !wdata[CFG_VALID]
    && cfg_reg[sel_reg].valid;

  for (genvar i = 0; i < NUM_HW; i++) begin : g_hw
    logic [2:0] sy_reg;
    logic flt_reg;
    always_ff @(posedge clk_sys) begin
      if (rst) begin
        sy_reg <= 3'h0;
        flt_reg <= 1'b0;
      end else begin
        sy_reg <= {sy_reg[1:0], hw_trigger[i]};
        if (sy_reg[1] == sy_reg[2]) flt_reg <= sy_reg[2];
      end
    end
    assign hw_rise[i] = (sy_reg[1] == sy_reg[2]) && sy_reg[2] && !flt_reg;
  end

  // per-entry module table, written through the selected index
  for (genvar m = 0; m < NUM_MOD; m++) begin : g_mod
    always_ff @(posedge clk_sys) begin
      if (rst) begin
        cfg_reg[m] <= (m < MOD_REQ) ? CFG_RST_USED : CFG_RST_FREE;
        bs0_reg[m] <= '0;
        bs1_reg[m] <= '0;
      end else if (wr && sel_reg == MW'(m)) begin
        if (addr == ADDR_MOD_CFG) cfg_reg[m] <= mod_cfg_t'(wdata[CFG_W-1:0]);
        if (addr == ADDR_BS0_ADDR) bs0_reg[m].addr <= wdata;
        if (addr == ADDR_BS0_SIZE) bs0_reg[m].size <= wdata;
        if (addr == ADDR_BS1_ADDR) bs1_reg[m].addr <= wdata;
        if (addr == ADDR_BS1_SIZE) bs1_reg[m].size <= wdata;
      end
    end
    assign vld[m] = cfg_reg[m].valid;
  end

  always_comb begin
    cnt = '0;
    for (int i = 0; i < NUM_MOD; i++) cnt = cnt + (MW + 1)'(vld[i]);
  end

  for (genvar t = 0; t < NUM_TRIG; t++) begin : g_trig
    always_ff @(posedge clk_sys) begin
      if (rst) begin
        lock_reg[t] <= 1'b0;
        lmod_reg[t] <= 2'h0;
      end else if (map_wr && tsel_reg == TW'(t)) begin
        lock_reg[t] <= wdata[TRIG_LOCK];
        lmod_reg[t] <= wdata[MW-1:0];
      end else if (del_now && lmod_reg[t] == sel_reg) begin
        lock_reg[t] <= 1'b0;
      end
    end
    assign eff[t] = lock_reg[t] ? lmod_reg[t]
      : (cnt == '0) ? 2'h0 : MW'(t % int'(cnt));
  end

  // one trigger per cycle: control stream, then pins, then software
  always_comb begin
    hw_take = '0;
    ctrl_take = ctrl_valid && ctrl_ready && state_reg == ST_ACTIVE && !sd_cmd;
    sw_take = 1'b0;
    trig_id = ctrl_data[TW-1:0];
    if (!ctrl_take && state_reg == ST_ACTIVE && !sd_cmd) begin
      for (int i = NUM_HW - 1; i >= 0; i--) begin
        if (hw_pend_reg[i]) begin
          hw_take = '0;
          hw_take[i] = 1'b1;
          trig_id = TW'(i);
        end
      end
      if (hw_take == '0 && sw_pend_reg) begin
        sw_take = 1'b1;
        trig_id = sw_id_reg;
      end
    end
    trig_go = ctrl_take || (hw_take != '0) || sw_take;
  end

  assign tgt = eff[trig_id];
  assign aligned = bs0_reg[tgt].addr[1:0] == 2'h0 && bs0_reg[tgt].size[1:0] == 2'h0;
  assign load_ok = trig_go && cnt != '0 && aligned;
  assign after_sd = (NEEDS_CLEARING && loaded_valid_reg && cur.has_clear)
    ? ST_CLEAR : ST_FETCH;
  assign err_st = soe_reg ? ST_SHUTDOWN : ST_ACTIVE;

  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      ST_ACTIVE: begin
        if (sd_cmd) state_next = ST_SHUTDOWN;
        else if (trig_go && cnt != '0 && !aligned) state_next = err_st;
        else if (load_ok && !loaded_valid_reg) state_next = ST_FETCH;
        else if (load_ok) begin
          unique case (cur.shut)
            SD_NONE: state_next = after_sd;
            SD_HW, SD_HW_SW: state_next = ST_SD_HW;
            SD_SW_HW: state_next = ST_SD_SW;
          endcase
        end
      end
      ST_SD_HW: begin
        if (rm_shutdown_ack) state_next = (cur.shut == SD_HW_SW) ? ST_SD_SW : after_sd;
      end
      ST_SD_SW: begin
        if (sd_ack) state_next = (cur.shut == SD_SW_HW) ? ST_SD_HW : after_sd;
      end
      ST_CLEAR: begin
        if (fetch_err) state_next = err_st;
        else if (fetch_done) state_next = ST_FETCH;
      end
      ST_FETCH: begin
        if (fetch_err) state_next = err_st;
        else if (fetch_done) state_next = ST_BOOT;
      end
      ST_BOOT: begin
        if (tcfg.rst == RS_HIGH || tcfg.rst == RS_LOW) state_next = ST_RESET;
        else if (tcfg.sw_start) state_next = ST_SU_SW;
        else state_next = ST_ACTIVE;
      end
      ST_RESET: begin
        if (rst_cnt_reg == 8'h00) state_next = tcfg.sw_start ? ST_SU_SW : ST_ACTIVE;
      end
      ST_SU_SW: begin
        if (su_ack) state_next = ST_ACTIVE;
      end
      ST_SHUTDOWN: begin
        if (go_cmd) state_next = ST_ACTIVE;
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      // start in shutdown, start-up after reset
      if (START_IN_SHUTDOWN) state_reg <= ST_SHUTDOWN;
      else if (HAS_POR && !SKIP_STARTUP) state_reg <= ST_BOOT;
      else state_reg <= ST_ACTIVE;
    end else begin
      state_reg <= state_next;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      loaded_valid_reg <= HAS_POR;
      loaded_reg <= POR_MOD;
      tgt_reg <= POR_MOD;
    end else begin
      if (state_reg == ST_ACTIVE && load_ok && !sd_cmd) tgt_reg <= tgt;
      if (state_next == ST_FETCH && state_reg != ST_FETCH) loaded_valid_reg <= 1'b0;
      if (state_reg == ST_FETCH && fetch_done && !fetch_err) begin
        loaded_valid_reg <= 1'b1;
        loaded_reg <= tgt_reg;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) rst_cnt_reg <= 8'h00;
    else if (state_reg == ST_BOOT) rst_cnt_reg <= tcfg.rst_len;
    else if (state_reg == ST_RESET && rst_cnt_reg != 8'h00) rst_cnt_reg <= rst_cnt_reg - 8'h01;
  end

  // idle level follows the module's polarity so active-low modules sit high
  always_ff @(posedge clk_sys) begin
    if (rst) rm_reset <= 1'b0;
    else if (state_next == ST_RESET) rm_reset <= tcfg.rst == RS_HIGH;
    else rm_reset <= tcfg.rst == RS_LOW;
  end

  assign fetching = state_next == ST_CLEAR || state_next == ST_FETCH;
  // req drops for the done cycle so a clear-then-load shows two requests
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      fetch_req <= 1'b0;
      fetch <= '0;
      rm_shutdown_req <= 1'b0;
    end else begin
      fetch_req <= fetching && !fetch_done && !fetch_err;
      fetch <= (state_next == ST_CLEAR) ? bs1_reg[loaded_reg] : bs0_reg[tgt_reg];
      rm_shutdown_req <= state_next == ST_SD_HW;
    end
  end

  // notices and errors: a new set wins over a same-cycle clear
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      sw_sd_reg <= 1'b0;
      sw_su_reg <= 1'b0;
      err_f_reg <= 1'b0;
      err_a_reg <= 1'b0;
    end else begin
      if (state_next == ST_SD_SW && state_reg != ST_SD_SW) sw_sd_reg <= 1'b1;
      else if (sd_ack) sw_sd_reg <= 1'b0;
      if (state_next == ST_SU_SW && state_reg != ST_SU_SW) sw_su_reg <= 1'b1;
      else if (su_ack) sw_su_reg <= 1'b0;
      if ((state_reg == ST_CLEAR || state_reg == ST_FETCH) && fetch_err) err_f_reg <= 1'b1;
      else if (wr && addr == ADDR_STATUS && wdata[ST_ERR_F]) err_f_reg <= 1'b0;
      if (state_reg == ST_ACTIVE && trig_go && cnt != '0 && !aligned) err_a_reg <= 1'b1;
      else if (wr && addr == ADDR_STATUS && wdata[ST_ERR_A]) err_a_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      hw_pend_reg <= '0;
      sw_pend_reg <= 1'b0;
      sw_id_reg <= 3'h0;
    end else begin
      hw_pend_reg <= (hw_pend_reg & ~hw_take) | hw_rise;
      if (wr && addr == ADDR_SW_TRIG) begin
        sw_pend_reg <= 1'b1;
        sw_id_reg <= wdata[TW-1:0];
      end else if (sw_take) begin
        sw_pend_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      soe_reg <= SOE_RESET;
      sel_reg <= 2'h0;
      tsel_reg <= 3'h0;
    end else if (wr) begin
      if (addr == ADDR_CTRL) soe_reg <= wdata[CTRL_SOE];
      if (addr == ADDR_MOD_SEL) sel_reg <= wdata[MW-1:0];
      if (addr == ADDR_TRIG_SEL) tsel_reg <= wdata[TW-1:0];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      rdata <= 32'h0000_0000;
    end else begin
      rdata <= 32'h0000_0000;
      if (rd) begin
        unique case (addr)
          ADDR_CTRL: rdata <= 32'(soe_reg);
          ADDR_STATUS: rdata <= {16'h0000, sw_su_reg, sw_sd_reg, err_a_reg,
            err_f_reg, loaded_reg, loaded_valid_reg, state_reg};
          ADDR_MOD_SEL: rdata <= 32'(sel_reg);
          ADDR_MOD_CFG: rdata <= 32'(cfg_reg[sel_reg]);
          ADDR_BS0_ADDR: rdata <= bs0_reg[sel_reg].addr;
          ADDR_BS0_SIZE: rdata <= bs0_reg[sel_reg].size;
          ADDR_BS1_ADDR: rdata <= bs1_reg[sel_reg].addr;
          ADDR_BS1_SIZE: rdata <= bs1_reg[sel_reg].size;
          ADDR_TRIG_SEL: rdata <= 32'(tsel_reg);
          ADDR_TRIG_MAP: rdata <= {23'h000000, lock_reg[tsel_reg], 6'h00, eff[tsel_reg]};
          default: rdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      status_valid <= 1'b0;
      status_data <= 16'h0000;
      ctrl_ready <= 1'b0;
    end else begin
      ctrl_ready <= HAS_CONTROL_CH && state_next == ST_ACTIVE && !ctrl_take;
      if (HAS_STATUS_CH && state_next != state_reg) begin
        status_valid <= 1'b1;
        status_data <= {2'h0, err_a_reg, err_f_reg, loaded_reg, loaded_valid_reg, state_next};
      end else if (status_ready) begin
        status_valid <= 1'b0;
      end
    end
  end

  a_start_shutdown: assert property (
    $past(rst) |-> (state_reg == ST_SHUTDOWN) == START_IN_SHUTDOWN)
    else $error("reset exit shutdown state wrong");
  a_error_shutdown: assert property (
    soe_reg && ((state_reg == ST_FETCH || state_reg == ST_CLEAR) && fetch_err
      || state_reg == ST_ACTIVE && trig_go && cnt != '0 && !aligned)
    |=> state_reg == ST_SHUTDOWN) else $error("error did not enter shutdown");
  a_boot_steps: assert property (
    $past(rst) |-> (state_reg == ST_BOOT)
      == (HAS_POR && !SKIP_STARTUP && !START_IN_SHUTDOWN))
    else $error("start-up after reset wrong");
  a_por_loaded: assert property (
    $past(rst) |-> loaded_valid_reg == HAS_POR && loaded_reg == POR_MOD)
    else $error("power-on module not loaded");
  a_sw_notice_type: assert property (
    $rose(sw_sd_reg) |-> cur.shut == SD_HW_SW || cur.shut == SD_SW_HW)
    else $error("software notified for wrong type");
  a_hw_then_sw: assert property (
    state_reg == ST_SD_HW && rm_shutdown_ack && cur.shut == SD_HW_SW
    |=> state_reg == ST_SD_SW && sw_sd_reg && !rm_shutdown_req)
    else $error("software notice not after module");
  a_sw_then_hw: assert property (
    state_reg == ST_SD_SW && sd_ack && cur.shut == SD_SW_HW
    |=> rm_shutdown_req && !sw_sd_reg) else $error("module notice not after software");
  a_startup_type: assert property (
    $rose(sw_su_reg) |-> tcfg.sw_start) else $error("start-up notice without type");
  a_reset_level: assert property (
    state_reg == ST_BOOT && tcfg.rst == RS_LOW |=> !rm_reset)
    else $error("active-low reset not driven low");
  a_reset_len: assert property (
    state_reg == ST_BOOT && tcfg.rst == RS_HIGH && tcfg.rst_len == 8'h01
    |=> rm_reset [*2] ##1 !rm_reset) else $error("reset length wrong");
  a_clear_first: assert property (
    state_reg == ST_CLEAR && fetch_done && !fetch_err |=> state_reg == ST_FETCH ##1 fetch_req)
    else $error("module load did not follow clearing");
  a_notice_release: assert property (
    $rose(sw_su_reg) |-> rm_reset == (tcfg.rst == RS_LOW))
    else $error("start-up notice during reset");

  c_full_swap: cover property (state_reg == ST_SD_SW ##[1:50] state_reg == ST_RESET);
  c_clear_load: cover property (state_reg == ST_CLEAR ##[1:50] state_reg == ST_BOOT);
  c_err_shut: cover property (err_a_reg && state_reg == ST_SHUTDOWN);
  c_hw_trig: cover property (hw_take != '0);
endmodule

// File: verification/module_side_model.sv
// Purpose: far-side model: reconfigurable module handshake and bitstream fetch path
// Assumes: same clock as the sequencer; answers after DLY idle cycles
// Notes: logs every fetched address so the bench can check load order
`timescale 1ns/1ps
module module_side_model
  import socket_seq_pkg::*;
#(
  parameter int DLY = 3
) (
  input wire logic clk_sys, // core clock
  input wire logic rst, // sync reset
  input wire logic rm_shutdown_req, // removal notice
  output logic rm_shutdown_ack, // ready for removal
  input wire logic fetch_req, // fetch request
  input wire fetch_t fetch, // fetch address and size
  output logic fetch_done, // fetch finished
  output logic fetch_err // fetch failed
);
  int fcnt;
  int scnt;
  int n_acks;
  logic [31:0] addr_log[$];
  initial begin
    rm_shutdown_ack = 1'b0;
    fetch_done = 1'b0;
    fetch_err = 1'b0;
    n_acks = 0;
  end
  always @(posedge clk_sys) begin
    rm_shutdown_ack <= 1'b0;
    if (rst) begin
      scnt <= 0;
    end else if (rm_shutdown_req && !rm_shutdown_ack) begin
      scnt <= scnt + 1;
      if (scnt == DLY) begin
        rm_shutdown_ack <= 1'b1;
        n_acks <= n_acks + 1;
        scnt <= 0;
      end
    end
  end
  // fetch path holds off DLY cycles, then one done pulse
  always @(posedge clk_sys) begin
    fetch_done <= 1'b0;
    if (rst) begin
      fcnt <= 0;
    end else if (fetch_req && !fetch_done) begin
      fcnt <= fcnt + 1;
      if (fcnt == DLY) begin
        fetch_done <= 1'b1;
        addr_log.push_back(fetch.addr);
        fcnt <= 0;
      end
    end
  end
endmodule

// File: verification/socket_module_sequencer_tb_top.sv
// Purpose: self-checking bench for the socket module sequencer
// Assumes: register port with one-cycle read latency, default build options
// Notes: one pin trigger and one control stream trigger are sent in the last test
`timescale 1ns/1ps
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin n_errors++; \
  $display("[ERR] t=%0t got=%h exp=%h", $time, (g), (e)); end end
module socket_module_sequencer_tb_top;
  import socket_seq_pkg::*;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [31:0] rdata;
  logic rm_shutdown_req, rm_shutdown_ack, rm_reset, fetch_req, fetch_done, fetch_err;
  fetch_t fetch;
  logic [1:0] hw_trig = 2'h0;
  logic ctrl_valid = 1'b0;
  logic [7:0] ctrl_data = 8'h00;
  logic ctrl_ready, status_valid;
  logic [15:0] status_data;
  int n_errors = 0;
  int checks_done = 0;
  int cyc = 0;
  int rst_hi = 0;
  logic [31:0] d;
  always #2.5 clk_sys = ~clk_sys;
  socket_module_sequencer u_socket_module_sequencer (.clk_sys(clk_sys), .rst(rst),
    .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .hw_trigger(hw_trig),
    .rm_shutdown_req(rm_shutdown_req), .rm_shutdown_ack(rm_shutdown_ack),
    .rm_reset(rm_reset), .fetch_req(fetch_req), .fetch(fetch), .fetch_done(fetch_done),
    .fetch_err(fetch_err), .status_valid(status_valid), .status_ready(1'b1),
    .status_data(status_data), .ctrl_valid(ctrl_valid), .ctrl_ready(ctrl_ready),
    .ctrl_data(ctrl_data));
  module_side_model #(.DLY(3)) u_module_side_model (.clk_sys(clk_sys), .rst(rst),
    .rm_shutdown_req(rm_shutdown_req), .rm_shutdown_ack(rm_shutdown_ack),
    .fetch_req(fetch_req), .fetch(fetch), .fetch_done(fetch_done), .fetch_err(fetch_err));
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (rm_reset === 1'b1) rst_hi <= rst_hi + 1;
    if (cyc == 20000) begin
      n_errors++;
      close_out();
    end
  end
  task automatic close_out();
    $display("checks=%0d errors=%0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk_sys);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge clk_sys);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [7:0] a, output logic [31:0] v);
    @(posedge clk_sys);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk_sys);
    rd <= 1'b0;
    #1 v = rdata;
  endtask
  // polls status until the state field matches, bounded
  task automatic wait_state(input logic [8:0] s);
    for (int i = 0; i < 200; i++) begin
      rd_reg(ADDR_STATUS, d);
      if (d[8:0] === s) return;
    end
    `CHK(d[8:0], s)
  endtask
  task automatic trig_map(input int t, input logic [8:0] e);
    wr_reg(ADDR_TRIG_SEL, 32'(t));
    rd_reg(ADDR_TRIG_MAP, d);
    `CHK(d[8:0], e)
  endtask
  task automatic t_reset();
    wait_state(ST_ACTIVE);
    `CHK(d[11:9], 3'h1)
    $display("test reset done");
  endtask
  task automatic t_mapping();
    for (int t = 0; t < NUM_TRIG; t++) trig_map(t, 9'(t % 3));
    wr_reg(ADDR_TRIG_SEL, 32'h1);
    wr_reg(ADDR_TRIG_MAP, 32'h102);
    wr_reg(ADDR_MOD_SEL, 32'h3);
    wr_reg(ADDR_MOD_CFG, 32'(CFG_RST_USED));
    trig_map(5, 9'h001);
    trig_map(1, 9'h102);
    wr_reg(ADDR_MOD_SEL, 32'h3);
    wr_reg(ADDR_MOD_CFG, 32'h0);
    wr_reg(ADDR_MOD_SEL, 32'h2);
    wr_reg(ADDR_MOD_CFG, 32'h0);
    trig_map(1, 9'h001);
    wr_reg(ADDR_MOD_CFG, 32'(CFG_RST_USED));
    trig_map(2, 9'h002);
    $display("test mapping done");
  endtask
  task automatic t_hw_sw_load();
    wr_reg(ADDR_MOD_SEL, 32'h0);
    wr_reg(ADDR_MOD_CFG, 32'h6000);
    wr_reg(ADDR_MOD_SEL, 32'h1);
    wr_reg(ADDR_MOD_CFG, 32'h4a02);
    wr_reg(ADDR_BS0_ADDR, 32'h100);
    wr_reg(ADDR_BS0_SIZE, 32'h40);
    wr_reg(ADDR_SW_TRIG, 32'h1);
    wait_state(ST_SD_SW);
    `CHK(u_module_side_model.n_acks, 1)
    `CHK({rm_shutdown_req, d[14]}, 2'b01)
    wr_reg(ADDR_SW_ACK, 32'h1);
    wait_state(ST_SU_SW);
    `CHK(rm_reset, 1'b0)
    `CHK(rst_hi, 2)
    `CHK(d[15], 1'b1)
    wr_reg(ADDR_SW_ACK, 32'h2);
    wait_state(ST_ACTIVE);
    `CHK(d[11:9], 3'h3)
    `CHK(u_module_side_model.addr_log[0], 32'h100)
    $display("test hw then sw load done");
  endtask
  task automatic t_sw_hw_clear();
    wr_reg(ADDR_MOD_CFG, 32'h7001);
    wr_reg(ADDR_BS1_ADDR, 32'h200);
    wr_reg(ADDR_BS1_SIZE, 32'h20);
    wr_reg(ADDR_MOD_SEL, 32'h2);
    // active-low reset, one cycle
    wr_reg(ADDR_MOD_CFG, 32'h4400);
    // only entries given a bitstream are ever triggered
    wr_reg(ADDR_BS0_ADDR, 32'h300);
    wr_reg(ADDR_BS0_SIZE, 32'h10);
    wr_reg(ADDR_SW_TRIG, 32'h2);
    wait_state(ST_SD_SW);
    `CHK(u_module_side_model.n_acks, 1)
    `CHK(rm_shutdown_req, 1'b0)
    wr_reg(ADDR_SW_ACK, 32'h1);
    wait_state(ST_ACTIVE);
    `CHK(u_module_side_model.n_acks, 2)
    `CHK(u_module_side_model.addr_log[1], 32'h200)
    `CHK(u_module_side_model.addr_log[2], 32'h300)
    `CHK(d[11:9], 3'h5)
    `CHK(rm_reset, 1'b1)
    $display("test sw then hw clear done");
  endtask
  task automatic t_align_err();
    wr_reg(ADDR_MOD_SEL, 32'h0);
    // misaligned address on purpose
    wr_reg(ADDR_BS0_ADDR, 32'h101);
    wr_reg(ADDR_SW_TRIG, 32'h0);
    wait_state(ST_SHUTDOWN);
    `CHK(d[13], 1'b1)
    `CHK(u_module_side_model.addr_log.size(), 3)
    wr_reg(ADDR_CTRL, 32'h5);
    wait_state(ST_ACTIVE);
    `CHK(d[11:9], 3'h5)
    $display("test align error done");
  endtask
  task automatic t_streams();
    wr_reg(ADDR_STATUS, 32'h2000);
    @(posedge clk_sys);
    ctrl_data <= 8'h01;
    ctrl_valid <= 1'b1;
    do @(posedge clk_sys); while (ctrl_ready !== 1'b1);
    ctrl_valid <= 1'b0;
    wait_state(ST_ACTIVE);
    `CHK(u_module_side_model.addr_log[3], 32'h100)
    `CHK(status_data, 16'h0601)
    `CHK({ctrl_ready, status_valid}, 2'b10)
    // pin 0 maps to the misaligned entry, so the load is refused
    @(posedge clk_sys);
    hw_trig <= 2'h1;
    wait_state(ST_SHUTDOWN);
    `CHK(d[13], 1'b1)
    $display("test streams and pins done");
  endtask
  initial begin
    repeat (3) @(posedge clk_sys);
    rst <= 1'b0;
    t_reset();
    t_mapping();
    t_hw_sw_load();
    t_sw_hw_clear();
    t_align_err();
    t_streams();
    close_out();
  end
endmodule
